/* core/dual_compare_pwm_mode_pkg.sv */
// Shared constants and types for the dual-pin PWM timer
package dual_compare_pwm_mode_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam int PRE_W = 5;
	localparam int NPIN = 2;
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	// Register byte offsets, one aligned word each
	localparam logic [ADDR_W-1:0] OFS_POL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IEN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_B_RET = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_A_ACT = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_B_ACT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_START = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h28;
	// Reset values and the counter maximum
	localparam logic [7:0] RST8 = 8'h00;
	localparam logic [CNT_W-1:0] RST16 = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [PRE_W-1:0] PRE_ZERO = 5'h00;
	// Field encodings
	localparam logic [2:0] CLR_ON_PERIOD = 3'h1;
	localparam logic [1:0] COMBO_DUAL_COMPARE_PWM_MODE = 2'h0;
	localparam logic MODE_DUAL_COMPARE_PWM_MODE = 1'b0;
	localparam logic [2:0] SRC_DIV1 = 3'h0;
	localparam logic [2:0] SRC_DIV2 = 3'h1;
	localparam logic [2:0] SRC_DIV4 = 3'h2;
	localparam logic [2:0] SRC_DIV8 = 3'h3;
	localparam logic [2:0] SRC_DIV32 = 3'h4;
	// Prescaler masks: tick when all masked bits are one
	localparam logic [PRE_W-1:0] MASK_DIV1 = 5'h00;
	localparam logic [PRE_W-1:0] MASK_DIV2 = 5'h01;
	localparam logic [PRE_W-1:0] MASK_DIV4 = 5'h03;
	localparam logic [PRE_W-1:0] MASK_DIV8 = 5'h07;
	localparam logic [PRE_W-1:0] MASK_DIV32 = 5'h1F;

	typedef struct packed {
		logic [5:0] unused;
		logic second_pin_polarity;
		logic first_pin_polarity;
	} pol_ctrl_t;

	typedef struct packed {
		logic [2:0] clear_sel;
		logic [1:0] edge_sel;
		logic [2:0] count_source;
	} cnt_ctrl_t;

	typedef struct packed {
		logic [2:0] unused;
		logic overflow;
		logic match_d;
		logic match_c;
		logic match_b;
		logic match_a;
	} irq_bits_t;

	typedef struct packed {
		logic mode_sel;
		logic [4:0] unused;
		logic [1:0] combination_mode;
	} func_ctrl_t;
endpackage

/* core/dual_pin_dual_compare_pwm_mode_timer.sv */
// Dual-pin PWM timer with one up-counter and an APB register slave
//
// Notes on behaviour
// - First pin: active on its active match, initial on the period match, inverted by bit 0.
// - Second pin: active on its active match, initial on its return match, inverted by bit 1.
// - With clear select at 001B the counter returns to zero on a period match.
// - Count source picks undivided, /2, /4, /8 or /32; codes 101 to 111 are not to be used.
// - The match A request is raised only while the A flag is set and its enable bit is 1.
// - The match B request is raised only while the B flag is set and its enable bit is 1.
// - The match C and D requests are each gated by their own enable bit.
// - The overflow request comes from the overflow flag only while the overflow enable bit is 1.
// - Each compare register is 16 bits wide and takes any value 0000H to FFFFH.
// - This PWM mode runs only with the mode-select bit at 0 and the combination field at 00B.
`timescale 1ns/1ps
`default_nettype none

module dual_pin_dual_compare_pwm_mode_timer #(
	parameter int ADDR_W = dual_compare_pwm_mode_pkg::ADDR_W,
	parameter int CNT_W = dual_compare_pwm_mode_pkg::CNT_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [dual_compare_pwm_mode_pkg::DATA_W-1:0] pwdata_in,
	output logic [dual_compare_pwm_mode_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic pwm_out_first_out,
	output logic pwm_out_second_out,
	output logic irq_out
);
	// Software-visible registers and the status vector
	dual_compare_pwm_mode_pkg::pol_ctrl_t pol_reg;
	dual_compare_pwm_mode_pkg::cnt_ctrl_t ctrl_reg;
	dual_compare_pwm_mode_pkg::irq_bits_t ien_reg;
	dual_compare_pwm_mode_pkg::irq_bits_t stat_reg;
	dual_compare_pwm_mode_pkg::irq_bits_t stat_next;
	dual_compare_pwm_mode_pkg::irq_bits_t event_now;
	dual_compare_pwm_mode_pkg::irq_bits_t clr_mask;
	dual_compare_pwm_mode_pkg::func_ctrl_t func_reg;
	logic start_reg;
	logic [CNT_W-1:0] period_reg;
	logic [CNT_W-1:0] b_ret_reg;
	logic [CNT_W-1:0] a_act_reg;
	logic [CNT_W-1:0] b_act_reg;

	// Counter, prescaler and match strobes
	logic [CNT_W-1:0] cnt_reg;
	logic [dual_compare_pwm_mode_pkg::PRE_W-1:0] pre_reg;
	logic [dual_compare_pwm_mode_pkg::PRE_W-1:0] pre_mask;
	logic src_ok;
	logic run;
	logic tick;
	logic hit_period;
	logic hit_b_ret;
	logic hit_a_act;
	logic hit_b_act;
	logic clear_now;

	// Bus answer and address decode
	logic pready_reg;
	logic [dual_compare_pwm_mode_pkg::DATA_W-1:0] prdata_reg;
	logic pslverr_reg;
	logic wr_fire;
	logic rd_take;
	logic addr_ok;
	logic [dual_compare_pwm_mode_pkg::DATA_W-1:0] rd_data;

	// Interrupt line and per-pin state
	logic irq_reg;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] act_reg;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] act_next;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] pin_reg;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] pol_bits;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] set_hit;
	logic [dual_compare_pwm_mode_pkg::NPIN-1:0] ret_hit;

	// APB: one wait state, write lands on the edge that samples pready high
	assign wr_fire = psel_in & penable_in & pwrite_in & pready_reg;
	assign rd_take = psel_in & penable_in & ~pready_reg;

	// Address decode and read mux; unmapped words read zero with an error
	always_comb begin
		rd_data = '0;
		addr_ok = 1'b1;
		unique case (paddr_in)
			dual_compare_pwm_mode_pkg::OFS_POL: rd_data = {24'h000000, pol_reg};
			dual_compare_pwm_mode_pkg::OFS_CTRL: rd_data = {24'h000000, ctrl_reg};
			dual_compare_pwm_mode_pkg::OFS_IEN: rd_data = {24'h000000, ien_reg};
			dual_compare_pwm_mode_pkg::OFS_STAT: rd_data = {24'h000000, stat_reg};
			dual_compare_pwm_mode_pkg::OFS_PERIOD: rd_data = {16'h0000, period_reg};
			dual_compare_pwm_mode_pkg::OFS_B_RET: rd_data = {16'h0000, b_ret_reg};
			dual_compare_pwm_mode_pkg::OFS_A_ACT: rd_data = {16'h0000, a_act_reg};
			dual_compare_pwm_mode_pkg::OFS_B_ACT: rd_data = {16'h0000, b_act_reg};
			dual_compare_pwm_mode_pkg::OFS_FUNC: rd_data = {24'h000000, func_reg};
			dual_compare_pwm_mode_pkg::OFS_START: rd_data = {31'h00000000, start_reg};
			dual_compare_pwm_mode_pkg::OFS_COUNT: rd_data = {16'h0000, cnt_reg};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answer flops; pready toggles so each access takes two cycles
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_reg <= 1'b0;
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (ce_in) begin
			pready_reg <= rd_take;
			pslverr_reg <= rd_take & ~addr_ok;
			if (rd_take && !pwrite_in) begin
				prdata_reg <= rd_data;
			end
		end
	end

	// Software-written configuration registers
	// Reserved bits are dropped here so they always read back as zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pol_reg <= dual_compare_pwm_mode_pkg::RST8;
			ctrl_reg <= dual_compare_pwm_mode_pkg::RST8;
			ien_reg <= dual_compare_pwm_mode_pkg::RST8;
			func_reg <= dual_compare_pwm_mode_pkg::RST8;
			start_reg <= 1'b0;
		end else if (ce_in && wr_fire) begin
			unique case (paddr_in)
				dual_compare_pwm_mode_pkg::OFS_POL: pol_reg <= {6'h00, pwdata_in[1:0]};
				dual_compare_pwm_mode_pkg::OFS_CTRL: ctrl_reg <= pwdata_in[7:0];
				dual_compare_pwm_mode_pkg::OFS_IEN: ien_reg <= {3'h0, pwdata_in[4:0]};
				dual_compare_pwm_mode_pkg::OFS_FUNC: func_reg <= {pwdata_in[7], 5'h00, pwdata_in[1:0]};
				dual_compare_pwm_mode_pkg::OFS_START: start_reg <= pwdata_in[0];
				default: ;
			endcase
		end
	end

	// Compare registers accept the full 16-bit range with no clipping
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			period_reg <= dual_compare_pwm_mode_pkg::RST16;
			b_ret_reg <= dual_compare_pwm_mode_pkg::RST16;
			a_act_reg <= dual_compare_pwm_mode_pkg::RST16;
			b_act_reg <= dual_compare_pwm_mode_pkg::RST16;
		end else if (ce_in && wr_fire) begin
			unique case (paddr_in)
				dual_compare_pwm_mode_pkg::OFS_PERIOD: period_reg <= pwdata_in[CNT_W-1:0];
				dual_compare_pwm_mode_pkg::OFS_B_RET: b_ret_reg <= pwdata_in[CNT_W-1:0];
				dual_compare_pwm_mode_pkg::OFS_A_ACT: a_act_reg <= pwdata_in[CNT_W-1:0];
				dual_compare_pwm_mode_pkg::OFS_B_ACT: b_act_reg <= pwdata_in[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// Mode gate: counting only in the dual-compare PWM combination
	assign run = start_reg & (func_reg.mode_sel == dual_compare_pwm_mode_pkg::MODE_DUAL_COMPARE_PWM_MODE)
		& (func_reg.combination_mode == dual_compare_pwm_mode_pkg::COMBO_DUAL_COMPARE_PWM_MODE);

	// Count source select; reserved codes give no tick at all
	always_comb begin
		pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV1;
		src_ok = 1'b1;
		unique case (ctrl_reg.count_source)
			dual_compare_pwm_mode_pkg::SRC_DIV1: pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV1;
			dual_compare_pwm_mode_pkg::SRC_DIV2: pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV2;
			dual_compare_pwm_mode_pkg::SRC_DIV4: pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV4;
			dual_compare_pwm_mode_pkg::SRC_DIV8: pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV8;
			dual_compare_pwm_mode_pkg::SRC_DIV32: pre_mask = dual_compare_pwm_mode_pkg::MASK_DIV32;
			default: src_ok = 1'b0;
		endcase
	end

	// Free-running prescaler, restarted whenever counting is off
	// Restarting it fixes the first tick at one divided period after start
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pre_reg <= dual_compare_pwm_mode_pkg::PRE_ZERO;
		end else if (ce_in) begin
			if (run) begin
				pre_reg <= pre_reg + 5'h01;
			end else begin
				pre_reg <= dual_compare_pwm_mode_pkg::PRE_ZERO;
			end
		end
	end

	// Tick only while running with a usable source
	assign tick = run & src_ok & ((pre_reg & pre_mask) == pre_mask);

	// Matches are checked against the value held at each tick
	assign hit_period = tick & (cnt_reg == period_reg);
	assign hit_b_ret = tick & (cnt_reg == b_ret_reg);
	assign hit_a_act = tick & (cnt_reg == a_act_reg);
	assign hit_b_act = tick & (cnt_reg == b_act_reg);
	assign clear_now = hit_period & (ctrl_reg.clear_sel == dual_compare_pwm_mode_pkg::CLR_ON_PERIOD);

	// Up-counter; holds its value while stopped so software can read it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_reg <= dual_compare_pwm_mode_pkg::RST16;
		end else if (ce_in && tick) begin
			if (clear_now) begin
				cnt_reg <= dual_compare_pwm_mode_pkg::RST16;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	// Event vector: C and D track the two active-level compares
	// Underflow is impossible in an up-count, so only overflow is flagged
	always_comb begin
		event_now = '0;
		event_now.match_a = hit_period;
		event_now.match_b = hit_b_ret;
		event_now.match_c = hit_a_act;
		event_now.match_d = hit_b_act;
		event_now.overflow = tick & (cnt_reg == dual_compare_pwm_mode_pkg::CNT_MAX) & ~clear_now;
	end

	// Write-one-to-clear; a fresh event in the same cycle wins the race
	always_comb begin
		clr_mask = '0;
		if (wr_fire && paddr_in == dual_compare_pwm_mode_pkg::OFS_STAT) begin
			clr_mask = pwdata_in[7:0];
		end
		stat_next = (stat_reg & ~clr_mask) | event_now;
	end

	// Status flags advance only while the clock enable is high
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stat_reg <= dual_compare_pwm_mode_pkg::RST8;
		end else if (ce_in) begin
			stat_reg <= stat_next;
		end
	end

	// Interrupt: each flag gated by its own enable, then merged on one line
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_reg <= 1'b0;
		end else if (ce_in) begin
			irq_reg <= (stat_reg.match_a & ien_reg.match_a)
				| (stat_reg.match_b & ien_reg.match_b)
				| (stat_reg.match_c & ien_reg.match_c)
				| (stat_reg.match_d & ien_reg.match_d)
				| (stat_reg.overflow & ien_reg.overflow);
		end
	end

	// Per-pin set and return sources
	assign pol_bits[dual_compare_pwm_mode_pkg::PIN_A] = pol_reg.first_pin_polarity;
	assign pol_bits[dual_compare_pwm_mode_pkg::PIN_B] = pol_reg.second_pin_polarity;
	assign set_hit[dual_compare_pwm_mode_pkg::PIN_A] = hit_a_act;
	assign ret_hit[dual_compare_pwm_mode_pkg::PIN_A] = hit_period;
	assign set_hit[dual_compare_pwm_mode_pkg::PIN_B] = hit_b_act;
	assign ret_hit[dual_compare_pwm_mode_pkg::PIN_B] = hit_b_ret;

	// Pin state; equal compares leave the pin at its initial level
	// A return match outranks a set match, so no one-tick glitch appears
	generate
		for (genvar i = 0; i < dual_compare_pwm_mode_pkg::NPIN; i++) begin : g_pin
			always_comb begin
				if (!run) begin
					act_next[i] = 1'b0;
				end else if (ret_hit[i]) begin
					act_next[i] = 1'b0;
				end else if (set_hit[i]) begin
					act_next[i] = 1'b1;
				end else begin
					act_next[i] = act_reg[i];
				end
			end

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					act_reg[i] <= 1'b0;
					pin_reg[i] <= 1'b0;
				end else if (ce_in) begin
					act_reg[i] <= act_next[i];
					pin_reg[i] <= act_next[i] ^ pol_bits[i];
				end
			end
		end
	endgenerate

	// Every output straight from a flop
	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign pwm_out_first_out = pin_reg[dual_compare_pwm_mode_pkg::PIN_A];
	assign pwm_out_second_out = pin_reg[dual_compare_pwm_mode_pkg::PIN_B];
	assign irq_out = irq_reg;
endmodule

`default_nettype wire

/* dv/dual_compare_pwm_mode_load.sv */
// Load model on the two PWM pins: measures period and high time
`timescale 1ns/1ps
`default_nettype none
module dual_compare_pwm_mode_load (
	input wire logic clk_in,
	input wire logic [1:0] pin_in,
	output logic [1:0][19:0] period_out,
	output logic [1:0][19:0] high_out
);
	logic [19:0] now_reg = 20'h00000;
	logic [1:0] last_reg = 2'h0;
	logic [1:0][19:0] rise_reg = '0;
	// A load sees only edges, so both figures are taken from the last rise
	always_ff @(posedge clk_in) begin
		now_reg <= now_reg + 20'h00001;
		last_reg <= pin_in;
		for (int i = 0; i < 2; i++) begin
			if (pin_in[i] && !last_reg[i]) begin
				period_out[i] <= now_reg - rise_reg[i];
				rise_reg[i] <= now_reg;
			end
			if (!pin_in[i] && last_reg[i])
				high_out[i] <= now_reg - rise_reg[i];
		end
	end
endmodule
`default_nettype wire

/* dv/dual_compare_pwm_mode_chk.sv */
// Port checker for the dual-pin PWM timer
`timescale 1ns/1ps
`default_nettype none
module dual_compare_pwm_mode_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic pwm_out_first_out,
	input wire logic pwm_out_second_out,
	input wire logic irq_out
);
	logic done, wr, rd, go, run_q;
	logic [1:0] pol_q, pins;
	logic [2:0] src_q, fn_q;
	logic [4:0] ien_q;
	logic [15:0] cmp_q [4];
	assign done = ce_in && psel_in && penable_in && pready_out;
	assign wr = done && pwrite_in;
	assign rd = done && !pwrite_in;
	assign go = run_q && fn_q == 3'h0;
	assign pins = {pwm_out_second_out, pwm_out_first_out};
	// Shadow of the registers from completed writes, so no peeking inside
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pol_q <= 2'h0;
			src_q <= 3'h0;
			fn_q <= 3'h0;
			run_q <= 1'b0;
			ien_q <= 5'h00;
			cmp_q <= '{default: 16'h0000};
		end else if (wr) begin
			case (paddr_in)
				dual_compare_pwm_mode_pkg::OFS_POL: pol_q <= pwdata_in[1:0];
				dual_compare_pwm_mode_pkg::OFS_CTRL: src_q <= pwdata_in[2:0];
				dual_compare_pwm_mode_pkg::OFS_IEN: ien_q <= pwdata_in[4:0];
				dual_compare_pwm_mode_pkg::OFS_FUNC: fn_q <= {pwdata_in[7], pwdata_in[1:0]};
				dual_compare_pwm_mode_pkg::OFS_START: run_q <= pwdata_in[0];
				default: if (paddr_in[7:4] == 4'h1) cmp_q[paddr_in[3:2]] <= pwdata_in[15:0];
			endcase
		end
	end
	default clocking @(posedge clk_in); endclocking
	// A frozen clock enable stalls everything, so checks pause with it
	default disable iff (rst_in || !ce_in);
	AST_STOP_PINS: assert property (!run_q ##1 $stable(pol_q) |-> pins == pol_q)
		else $error("pins off initial level while stopped");
	AST_BAD_SRC: assert property (go && src_q > 3'h4
		&& $stable({go, pol_q}) |=> $stable(pins))
		else $error("pins moved with an unusable count source");
	AST_CMP_READ: assert property (rd && paddr_in[7:4] == 4'h1
		|-> prdata_out == {16'h0000, cmp_q[paddr_in[3:2]]})
		else $error("compare register readback wrong");
	AST_POL_READ: assert property (rd && paddr_in == dual_compare_pwm_mode_pkg::OFS_POL
		|-> prdata_out == {30'h0, pol_q})
		else $error("polarity readback wrong");
	AST_IRQ_MASK: assert property (irq_out |-> $past(ien_q) != 5'h00)
		else $error("interrupt with every enable off");
	AST_W1C: assert property (wr && paddr_in == dual_compare_pwm_mode_pkg::OFS_STAT
		&& pwdata_in[4:0] == 5'h1F && !go |-> ##2 !irq_out)
		else $error("interrupt stays after clearing");
	AST_WAIT: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
		else $error("ready not in second access cycle");
	// Read data only means something on a read; a refused write leaves it as it was
	AST_UNMAPPED: assert property (done && paddr_in > dual_compare_pwm_mode_pkg::OFS_COUNT
		|-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
		else $error("unmapped access not refused");
	COV_PIN: cover property ($rose(pwm_out_first_out));
	COV_IRQ: cover property ($rose(irq_out));
	COV_ERR: cover property (pslverr_out);
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the dual-pin PWM timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out, rd;
	logic err;
	logic pready_out, pslverr_out, pwm_out_first_out, pwm_out_second_out, irq_out;
	logic [1:0][19:0] per, hi;
	logic [1:0] pl;
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 57;
	int p, aa, ba, br, d, mk;
	dual_pin_dual_compare_pwm_mode_timer i_dual_pin_dual_compare_pwm_mode_timer (.*);
	dual_compare_pwm_mode_load i_dual_compare_pwm_mode_load (.clk_in(clk_in), .pin_in({pwm_out_second_out, pwm_out_first_out}),
		.period_out(per), .high_out(hi));
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results;
		$display("Checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Setup, then access held until ready; a spare edge keeps drives apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= v;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	// Counter holds while stopped and has no write path; a reset restarts it at zero
	task automatic rst_pulse;
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// High time seen by the load; inverted polarity swaps high and low
	function automatic logic [31:0] high_len(input logic inv, input int act, input int len);
		return 32'(inv ? len - act : act);
	endfunction
	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		for (int a = 0; a <= 'h2C; a += 4) begin
			rdc("reset value", a[7:0], 32'h0);
			chk("slverr", {31'h0, a == 'h2C}, {31'h0, err});
		end
		ce_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		ce_in <= 1'b1;
		wr(dual_compare_pwm_mode_pkg::OFS_POL, 32'hFFFFFFFF);
		rdc("polarity", dual_compare_pwm_mode_pkg::OFS_POL, 32'h3);
		for (int a = 'h10; a <= 'h1C; a += 4) begin
			wr(a[7:0], 32'hFFFFFFFF);
			rdc("compare max", a[7:0], 32'h0000FFFF);
			wr(a[7:0], 32'h0);
			rdc("compare min", a[7:0], 32'h0);
		end
		// One run per usable count source, random compares kept ordered
		for (int c = 0; c < 5; c++) begin
			rst_pulse();
			p = 8 + ($random(seed) & 31);
			aa = ($random(seed) & 255) % p;
			ba = ($random(seed) & 255) % p;
			br = ba + 1 + ($random(seed) & 255) % (p - ba);
			pl = 2'($random(seed));
			mk = ($random(seed) & 31) | (1 << (c % 4));
			d = (c == 4) ? 32 : 1 << c;
			wr(dual_compare_pwm_mode_pkg::OFS_POL, 32'(pl));
			wr(dual_compare_pwm_mode_pkg::OFS_CTRL, {24'h0, 3'h1, 2'h0, 3'(c)});
			wr(dual_compare_pwm_mode_pkg::OFS_PERIOD, 32'(p));
			wr(dual_compare_pwm_mode_pkg::OFS_B_RET, 32'(br));
			wr(dual_compare_pwm_mode_pkg::OFS_A_ACT, 32'(aa));
			wr(dual_compare_pwm_mode_pkg::OFS_B_ACT, 32'(ba));
			wr(dual_compare_pwm_mode_pkg::OFS_IEN, 32'(mk));
			wr(dual_compare_pwm_mode_pkg::OFS_START, 32'h1);
			repeat (3 * (p + 1) * d + 2 * d + 8) @(posedge clk_in);
			chk("period first", 32'((p + 1) * d), {12'h0, per[0]});
			chk("period second", 32'((p + 1) * d), {12'h0, per[1]});
			chk("high first", high_len(pl[0], (p - aa) * d, (p + 1) * d), {12'h0, hi[0]});
			chk("high second", high_len(pl[1], (br - ba) * d, (p + 1) * d), {12'h0, hi[1]});
			rdc("status", dual_compare_pwm_mode_pkg::OFS_STAT, 32'hF);
			chk("irq", 32'h1, {31'h0, irq_out});
			wr(dual_compare_pwm_mode_pkg::OFS_IEN, 32'h0);
			repeat (2) @(posedge clk_in);
			chk("irq masked", 32'h0, {31'h0, irq_out});
			wr(dual_compare_pwm_mode_pkg::OFS_START, 32'h0);
			wr(dual_compare_pwm_mode_pkg::OFS_STAT, 32'h1F);
			rdc("status cleared", dual_compare_pwm_mode_pkg::OFS_STAT, 32'h0);
		end
		// Forbidden sources and a non-PWM mode must leave the counter still
		for (int c = 5; c < 9; c++) begin
			rst_pulse();
			wr(dual_compare_pwm_mode_pkg::OFS_FUNC, (c == 8) ? 32'h80 : 32'h0);
			wr(dual_compare_pwm_mode_pkg::OFS_CTRL, {24'h0, 3'h1, 2'h0, (c == 8) ? 3'h0 : 3'(c)});
			wr(dual_compare_pwm_mode_pkg::OFS_START, 32'h1);
			repeat (70) @(posedge clk_in);
			rdc("held count", dual_compare_pwm_mode_pkg::OFS_COUNT, 32'h0);
			wr(dual_compare_pwm_mode_pkg::OFS_START, 32'h0);
		end
		results();
	end
	initial begin
		repeat (30000) @(posedge clk_in);
		error_cnt++;
		results();
	end
endmodule
bind dual_pin_dual_compare_pwm_mode_timer dual_compare_pwm_mode_chk i_dual_compare_pwm_mode_chk (.*);
`default_nettype wire
